// >>> test/drs_sva.sv
`timescale 1ns/100ps
module drs_sva (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_rx_dr_swap,
   input wire logic i_rx_accept,
   input wire logic i_tx_sent,
   input wire logic o_tx_req,
   input wire logic [2:0] o_tx_kind,
   input wire logic o_eval_req,
   input wire logic o_role_change_req,
   input wire logic o_data_role
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);
   // ***************
   // decoded causes
   // ***************
   wire ctrl_wr = i_psel && i_penable && i_pwrite && (i_paddr == drs_pkg::CTRL_OFFSET);
   wire wr_swap = ctrl_wr && i_pwdata[0];
   wire wr_ok = ctrl_wr && i_pwdata[3];
   wire wr_nok = ctrl_wr && i_pwdata[4];
   wire wr_wait = ctrl_wr && i_pwdata[5];
   wire wr_done = ctrl_wr && i_pwdata[6];
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   sequence s_msg_done;
      $past(i_tx_sent) || $past(i_rx_accept) || $past(i_tx_sent, 2) || $past(i_rx_accept, 2);
   endsequence
   // the cause may lead the send by one or two edges, never more
   property p_sent_after(logic [2:0] k, logic c);
      o_tx_req && o_tx_kind == k |-> $past(c) || $past(c, 2);
   endproperty
   // ***************
   // assertions
   // ***************
   a_apb_ready: assert property (s_setup |=> o_pready) else $error("no ready after setup");
   a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   a_kind_idle: assert property (!o_tx_req |-> o_tx_kind == 3'h0)
      else $error("message kind without request");
   a_tx_pulse: assert property (o_tx_req |=> !o_tx_req)
      else $error("send request longer than a cycle");
   a_eval_cause: assert property (o_eval_req |-> $past(i_rx_dr_swap) || $past(i_rx_dr_swap, 2))
      else $error("evaluation asked without swap request");
   a_accept_cause: assert property (p_sent_after(3'h1, wr_ok))
      else $error("accept sent without approval");
   a_reject_cause: assert property (p_sent_after(3'h2, wr_nok))
      else $error("reject sent without refusal");
   a_wait_cause: assert property (p_sent_after(3'h3, wr_wait))
      else $error("wait sent without defer answer");
   a_swap_cause: assert property (p_sent_after(3'h4, wr_swap))
      else $error("swap sent without manager request");
   a_change_cause: assert property (o_role_change_req |-> s_msg_done)
      else $error("role change asked without accept");
   a_change_pulse: assert property (o_role_change_req |=> !o_role_change_req)
      else $error("role change request longer than a cycle");
   a_role_fall: assert property ($fell(o_data_role) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("role changed without confirmation");
   a_role_rise: assert property (##1 !$rose(o_data_role))
      else $error("role returned downstream");
endmodule : drs_sva
bind data_role_swap_dfp_to_ufp drs_sva u_sva (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_rx_dr_swap(i_rx_dr_swap), .i_rx_accept(i_rx_accept), .i_tx_sent(i_tx_sent),
   .o_tx_req(o_tx_req), .o_tx_kind(o_tx_kind), .o_eval_req(o_eval_req),
   .o_role_change_req(o_role_change_req), .o_data_role(o_data_role));

// >>> test/proto_model.sv
`timescale 1ns/100ps
module proto_model (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_tx_req,
   input wire logic [2:0] i_tx_kind,
   input wire logic i_slow,
   input wire logic i_fail,
   output logic o_tx_sent,
   output logic o_tx_failed,
   output logic [2:0] o_last_kind
);
   logic [3:0] wait_reg;
   // one message in flight only: the engine never overlaps sends
   always_ff @(posedge i_clk_sys) begin
      o_tx_sent <= 1'b0;
      o_tx_failed <= 1'b0;
      if (i_reset) begin
         wait_reg <= 4'h0;
         o_last_kind <= 3'h0;
      end else if (i_tx_req) begin
         wait_reg <= i_slow ? 4'h9 : 4'h1;
         o_last_kind <= i_tx_kind;
      end else if (wait_reg != 4'h0) begin
         wait_reg <= wait_reg - 4'h1;
         if (wait_reg == 4'h1) begin
            o_tx_sent <= !i_fail;
            o_tx_failed <= i_fail;
         end
      end
   end
endmodule : proto_model

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h00000000;
   logic [4:0] strobe = 5'h00;
   logic slow = 1'b0;
   logic fail = 1'b0;
   logic rcr_seen = 1'b0;
   logic eval_seen = 1'b0;
   logic [31:0] o_prdata, rd;
   logic o_pready, o_pslverr, o_tx_req, o_eval_req, o_role_change_req, o_data_role, o_irq;
   logic tx_sent, tx_failed, err;
   logic [2:0] o_tx_kind, last_kind;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   data_role_swap_dfp_to_ufp DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_rx_dr_swap(strobe[0]), .i_rx_accept(strobe[1]), .i_rx_reject(strobe[2]),
      .i_rx_wait(strobe[3]), .i_tx_sent(tx_sent), .i_tx_failed(tx_failed),
      .i_proto_error(strobe[4]), .o_tx_req(o_tx_req), .o_tx_kind(o_tx_kind),
      .o_eval_req(o_eval_req), .o_role_change_req(o_role_change_req),
      .o_data_role(o_data_role), .o_irq(o_irq));
   proto_model partner (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_tx_req(o_tx_req),
      .i_tx_kind(o_tx_kind), .i_slow(slow), .i_fail(fail), .o_tx_sent(tx_sent),
      .o_tx_failed(tx_failed), .o_last_kind(last_kind));
   // ***************
   // clock, watchdog
   // ***************
   initial begin
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (o_role_change_req === 1'b1) rcr_seen <= 1'b1;
      if (o_eval_req === 1'b1) eval_seen <= 1'b1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ***************
   // tasks
   // ***************
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      comparisons++;
      if (act !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk
   // no cycle count assumed: wait for pready, bounded
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= addr;
      i_pwdata <= data;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      err = o_pslverr;
      if (n >= 20) fail_count++;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   // polls state and role fields, compares after the last read
   task automatic wait_state(input logic [31:0] exp, input int limit);
      int i;
      for (i = 0; i < limit; i++) begin
         apb(1'b0, drs_pkg::STATUS_OFFSET, 32'h00000000);
         if ((rd & 32'h0000001F) === exp) break;
      end
      chk(rd & 32'h0000001F, exp);
   endtask : wait_state
   task automatic pulse(input int idx);
      @(posedge i_clk_sys);
      strobe <= 5'h01 << idx;
      @(posedge i_clk_sys);
      strobe <= 5'h00;
   endtask : pulse
   task automatic do_reset;
      @(posedge i_clk_sys);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
   endtask : do_reset
   // ***************
   // scenarios
   // ***************
   initial begin
      int k;
      int bits[3];
      logic [2:0] kinds[3];
      bits = '{4, 5, 3};
      kinds = '{3'h2, 3'h3, 3'h1};
      repeat (20) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      wait_state(32'h00000010, 1);
      chk({31'h0, o_data_role}, 32'h00000001);
      apb(1'b0, drs_pkg::IRQ_MASK_OFFSET, 32'h00000000);
      chk(rd, 32'h00000000);
      apb(1'b0, 12'h020, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
      apb(1'b1, drs_pkg::IRQ_MASK_OFFSET, 32'h00000010);
      slow <= 1'b1;
      for (k = 0; k < 3; k++) begin
         chk({31'h0, o_irq}, 32'h00000000);
         pulse(0);
         wait_state(32'h00000012, 20);
         chk({31'h0, o_irq}, 32'h00000001);
         apb(1'b0, drs_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
         chk(rd & 32'h00000010, 32'h00000010);
         apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000001 << bits[k]);
         wait_state((k == 2) ? 32'h00000015 : 32'h00000010, 40);
         chk({29'h0, last_kind}, {29'h0, kinds[k]});
      end
      chk({31'h0, rcr_seen}, 32'h00000001);
      chk({31'h0, eval_seen}, 32'h00000001);
      chk({31'h0, o_irq}, 32'h00000000);
      apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000040);
      wait_state(32'h00000000, 20);
      chk({31'h0, o_data_role}, 32'h00000000);
      apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000001);
      wait_state(32'h00000000, 3);
      chk({29'h0, last_kind}, 32'h00000001);
      for (k = 0; k < 2; k++) begin
         do_reset();
         apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000002 | (k << 2));
         pulse(0);
         wait_state(32'h00000017 + k, 20);
      end
      for (k = 1; k < 5; k++) begin
         do_reset();
         apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000001);
         wait_state(32'h00000016, 20);
         chk(rd & 32'h00000020, 32'h00000020);
         chk({29'h0, last_kind}, 32'h00000004);
         if (k < 4) pulse(k);
         wait_state((k == 1) ? 32'h00000015 : 32'h00000010, (k == 4) ? 1500 : 20);
         chk(rd & 32'h00000020, 32'h00000000);
      end
      do_reset();
      pulse(0);
      wait_state(32'h00000012, 20);
      pulse(4);
      wait_state(32'h00000019, 20);
      do_reset();
      fail <= 1'b1;
      pulse(0);
      wait_state(32'h00000012, 20);
      apb(1'b1, drs_pkg::CTRL_OFFSET, 32'h00000008);
      wait_state(32'h00000019, 40);
      wrap_up();
   end
endmodule : tb

// >>> verilog/data_role_swap_dfp_to_ufp.sv
`timescale 1ns/100ps
// Summary of operation
// - swap starts only from source ready or sink ready
// - swap request received without alternate modes goes to evaluate
// - swap request received with alternate modes goes to hard reset
// - policy manager swap request from ready, while downstream, goes to send-request
// - evaluate asks policy manager; it answers ok, not ok or wait
// - ok answer goes to accept-request
// - not ok or further evaluation goes to reject-request
// - accept-request sends Accept, then goes to change-to-upstream
// - change-to-upstream asks policy manager to become upstream facing
// - confirmed role change returns to the ready state
// - send-request sends swap request and starts response timer
// - leaving send-request stops the response timer
// - Reject, Wait or timeout in send-request returns to ready, downstream
// - Accept in send-request goes to change-to-upstream
// - reject-request sends Reject when the swap is not possible
// - reject-request sends Wait when further evaluation is needed
// - after Reject or Wait is sent, return to ready, still downstream
// - protocol error or failed send during swap goes to error recovery
module data_role_swap_dfp_to_ufp (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rx_dr_swap,
   input wire logic i_rx_accept,
   input wire logic i_rx_reject,
   input wire logic i_rx_wait,
   input wire logic i_tx_sent,
   input wire logic i_tx_failed,
   input wire logic i_proto_error,
   output logic o_tx_req,
   output logic [2:0] o_tx_kind,
   output logic o_eval_req,
   output logic o_role_change_req,
   output logic o_data_role,
   output logic o_irq
);

   // ***********************************************
   // apb slave
   // ***********************************************
   logic [7:0] ctrl_reg;
   logic [drs_pkg::IRQ_W-1:0] irq_status_reg;
   logic [drs_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [drs_pkg::IRQ_W-1:0] irq_events;
   drs_pkg::swap_state_t state_reg;
   drs_pkg::swap_state_t state_next;
   logic [drs_pkg::TIMER_W-1:0] timer_reg;
   logic timer_run_reg;
   logic role_reg;
   logic [31:0] rdata_next;
   drs_pkg::proto_rx_t rx;

   wire apb_access = i_psel && i_penable;
   wire apb_wr = apb_access && i_pwrite;
   wire apb_rd = apb_access && !i_pwrite;
   wire hit_ctrl = (i_paddr == drs_pkg::CTRL_OFFSET);
   wire hit_status = (i_paddr == drs_pkg::STATUS_OFFSET);
   wire hit_irq = (i_paddr == drs_pkg::IRQ_STATUS_OFFSET);
   wire hit_mask = (i_paddr == drs_pkg::IRQ_MASK_OFFSET);
   wire hit_timer = (i_paddr == drs_pkg::TIMER_OFFSET);
   wire hit_any = hit_ctrl || hit_status || hit_irq || hit_mask || hit_timer;
   wire ctrl_wr = apb_wr && hit_ctrl;
   // clear on the setup edge, where read data is captured, so no event slips between
   wire irq_rd = i_psel && !i_penable && !i_pwrite && hit_irq;

   // policy manager strobes are self-clearing ctrl bits; levels stay set
   wire swap_req_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_SWAP_REQ_BIT];
   wire eval_ok_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_EVAL_OK_BIT];
   wire eval_nok_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_EVAL_NOK_BIT];
   wire eval_wait_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_EVAL_WAIT_BIT];
   wire role_done_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_ROLE_DONE_BIT];
   wire recover_pulse = ctrl_wr && i_pwdata[drs_pkg::CTRL_RECOVER_BIT];
   wire modal_active = ctrl_reg[drs_pkg::CTRL_MODAL_BIT];
   wire power_sink = ctrl_reg[drs_pkg::CTRL_SINK_BIT];

   assign rx = '{dr_swap: i_rx_dr_swap, accept: i_rx_accept, reject: i_rx_reject,
                 wait_msg: i_rx_wait, sent: i_tx_sent, send_failed: i_tx_failed,
                 proto_error: i_proto_error};

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_ctrl) begin
         rdata_next[2:1] = ctrl_reg[2:1];
      end else if (hit_status) begin
         rdata_next[3:0] = state_reg;
         rdata_next[4] = role_reg;
         rdata_next[5] = timer_run_reg;
      end else if (hit_irq) begin
         rdata_next[drs_pkg::IRQ_W-1:0] = irq_status_reg;
      end else if (hit_mask) begin
         rdata_next[drs_pkg::IRQ_W-1:0] = irq_mask_reg;
      end else if (hit_timer) begin
         rdata_next[drs_pkg::TIMER_W-1:0] = timer_reg;
      end
   end

   // zero wait states: pready is a flop that rises in the first access cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !hit_any;
         o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rdata_next : 32'h0000_0000;
      end
   end

   // only the level bits are stored
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ctrl_reg <= drs_pkg::CTRL_RESET;
         irq_mask_reg <= drs_pkg::IRQ_MASK_RESET;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg[2:1] <= i_pwdata[2:1];
         end
         if (apb_wr && hit_mask) begin
            irq_mask_reg <= i_pwdata[drs_pkg::IRQ_W-1:0];
         end
      end
   end

   // ***********************************************
   // swap state machine
   // ***********************************************
   wire in_ready = (state_reg == drs_pkg::SOURCE_READY_STATE) ||
                   (state_reg == drs_pkg::SINK_READY_STATE);
   wire in_swap = !in_ready && (state_reg != drs_pkg::ERROR_RECOVERY_STATE) &&
                  (state_reg != drs_pkg::SOURCE_HARD_RESET_STATE) &&
                  (state_reg != drs_pkg::SINK_HARD_RESET_STATE);
   wire timer_expired = timer_run_reg && (timer_reg == '0);
   wire swap_error = rx.proto_error || rx.send_failed;
   drs_pkg::swap_state_t ready_state;
   assign ready_state = power_sink ? drs_pkg::SINK_READY_STATE : drs_pkg::SOURCE_READY_STATE;

   always_comb begin
      state_next = state_reg;
      if (in_swap && swap_error) begin
         state_next = drs_pkg::ERROR_RECOVERY_STATE;
      end else begin
         case (state_reg)
            drs_pkg::SOURCE_READY_STATE,
            drs_pkg::SINK_READY_STATE: begin
               state_next = ready_state;
               if (rx.dr_swap && !modal_active) begin
                  state_next = drs_pkg::EVALUATE_REQUEST_STATE;
               end else if (rx.dr_swap) begin
                  state_next = power_sink ? drs_pkg::SINK_HARD_RESET_STATE
                                          : drs_pkg::SOURCE_HARD_RESET_STATE;
               end else if (swap_req_pulse && role_reg == drs_pkg::ROLE_DOWNSTREAM) begin
                  state_next = drs_pkg::SEND_REQUEST_STATE;
               end
            end
            drs_pkg::EVALUATE_REQUEST_STATE: begin
               if (eval_ok_pulse) begin
                  state_next = drs_pkg::ACCEPT_REQUEST_STATE;
               end else if (eval_nok_pulse || eval_wait_pulse) begin
                  state_next = drs_pkg::REJECT_REQUEST_STATE;
               end
            end
            drs_pkg::ACCEPT_REQUEST_STATE: begin
               if (rx.sent) begin
                  state_next = drs_pkg::CHANGE_TO_UPSTREAM_STATE;
               end
            end
            drs_pkg::CHANGE_TO_UPSTREAM_STATE: begin
               if (role_done_pulse) begin
                  state_next = ready_state;
               end
            end
            drs_pkg::SEND_REQUEST_STATE: begin
               if (rx.accept) begin
                  state_next = drs_pkg::CHANGE_TO_UPSTREAM_STATE;
               end else if (rx.reject || rx.wait_msg || timer_expired) begin
                  state_next = ready_state;
               end
            end
            drs_pkg::REJECT_REQUEST_STATE: begin
               if (rx.sent) begin
                  state_next = ready_state;
               end
            end
            drs_pkg::SOURCE_HARD_RESET_STATE,
            drs_pkg::SINK_HARD_RESET_STATE,
            drs_pkg::ERROR_RECOVERY_STATE: begin
               // hard reset and recovery are handled elsewhere; software releases
               if (recover_pulse) begin
                  state_next = ready_state;
               end
            end
            default: begin
               state_next = ready_state;
            end
         endcase
      end
   end

   wire entering = (state_next != state_reg);
   wire enter_eval = entering && state_next == drs_pkg::EVALUATE_REQUEST_STATE;
   wire enter_accept = entering && state_next == drs_pkg::ACCEPT_REQUEST_STATE;
   wire enter_reject = entering && state_next == drs_pkg::REJECT_REQUEST_STATE;
   wire enter_change = entering && state_next == drs_pkg::CHANGE_TO_UPSTREAM_STATE;
   wire enter_send = entering && state_next == drs_pkg::SEND_REQUEST_STATE;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_reg <= drs_pkg::SOURCE_READY_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ***********************************************
   // sender response timer
   // ***********************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         timer_reg <= '0;
         timer_run_reg <= 1'b0;
      end else if (enter_send) begin
         timer_reg <= drs_pkg::TIMER_W'(drs_pkg::SENDER_RESPONSE_CYCLES - 1);
         timer_run_reg <= 1'b1;
      end else if (state_reg == drs_pkg::SEND_REQUEST_STATE && entering) begin
         timer_run_reg <= 1'b0;
         timer_reg <= '0;
      end else if (timer_run_reg && timer_reg != '0) begin
         timer_reg <= timer_reg - 1'b1;
      end
   end

   // ***********************************************
   // requests to protocol layer and policy manager
   // ***********************************************
   // one-cycle pulses on state entry; the far side latches them
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_tx_req <= 1'b0;
         o_tx_kind <= drs_pkg::MSG_NONE;
         o_eval_req <= 1'b0;
         o_role_change_req <= 1'b0;
      end else begin
         o_tx_req <= enter_accept || enter_reject || enter_send;
         o_eval_req <= enter_eval;
         o_role_change_req <= enter_change;
         if (enter_accept) begin
            o_tx_kind <= drs_pkg::MSG_ACCEPT;
         end else if (enter_reject && eval_wait_pulse && !eval_nok_pulse) begin
            o_tx_kind <= drs_pkg::MSG_WAIT;
         end else if (enter_reject) begin
            o_tx_kind <= drs_pkg::MSG_REJECT;
         end else if (enter_send) begin
            o_tx_kind <= drs_pkg::MSG_DR_SWAP;
         end else begin
            o_tx_kind <= drs_pkg::MSG_NONE;
         end
      end
   end

   // ***********************************************
   // data role and interrupts
   // ***********************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         role_reg <= drs_pkg::ROLE_DOWNSTREAM;
      end else if (state_reg == drs_pkg::CHANGE_TO_UPSTREAM_STATE && role_done_pulse) begin
         role_reg <= drs_pkg::ROLE_UPSTREAM;
      end
   end

   assign o_data_role = role_reg;

   always_comb begin
      irq_events = '0;
      irq_events[drs_pkg::IRQ_SWAP_DONE_BIT] =
         state_reg == drs_pkg::CHANGE_TO_UPSTREAM_STATE && role_done_pulse;
      irq_events[drs_pkg::IRQ_SWAP_REFUSED_BIT] =
         state_reg == drs_pkg::SEND_REQUEST_STATE && entering && !rx.accept;
      irq_events[drs_pkg::IRQ_HARD_RESET_BIT] = entering &&
         (state_next == drs_pkg::SOURCE_HARD_RESET_STATE ||
          state_next == drs_pkg::SINK_HARD_RESET_STATE);
      irq_events[drs_pkg::IRQ_ERROR_BIT] = entering &&
         state_next == drs_pkg::ERROR_RECOVERY_STATE;
      irq_events[drs_pkg::IRQ_EVAL_BIT] = enter_eval;
      irq_events[drs_pkg::IRQ_ROLE_BIT] = enter_change;
   end

   // a new event in the read cycle survives the read clear
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         irq_status_reg <= '0;
         o_irq <= 1'b0;
      end else begin
         irq_status_reg <= (irq_rd ? '0 : irq_status_reg) | irq_events;
         o_irq <= |(((irq_rd ? '0 : irq_status_reg) | irq_events) & irq_mask_reg);
      end
   end

endmodule : data_role_swap_dfp_to_ufp

// >>> verilog/drs_pkg.sv
package drs_pkg;

   // ***********************************************
   // register map (word offsets are byte addresses)
   // ***********************************************
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
   localparam logic [11:0] IRQ_MASK_OFFSET = 12'h00C;
   localparam logic [11:0] TIMER_OFFSET = 12'h010;

   // ctrl fields
   localparam int CTRL_SWAP_REQ_BIT = 0;
   localparam int CTRL_MODAL_BIT = 1;
   localparam int CTRL_SINK_BIT = 2;
   localparam int CTRL_EVAL_OK_BIT = 3;
   localparam int CTRL_EVAL_NOK_BIT = 4;
   localparam int CTRL_EVAL_WAIT_BIT = 5;
   localparam int CTRL_ROLE_DONE_BIT = 6;
   localparam int CTRL_RECOVER_BIT = 7;

   // interrupt status bits
   localparam int IRQ_W = 6;
   localparam int IRQ_SWAP_DONE_BIT = 0;
   localparam int IRQ_SWAP_REFUSED_BIT = 1;
   localparam int IRQ_HARD_RESET_BIT = 2;
   localparam int IRQ_ERROR_BIT = 3;
   localparam int IRQ_EVAL_BIT = 4;
   localparam int IRQ_ROLE_BIT = 5;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

   // data role encoding: 1 = downstream facing
   localparam logic ROLE_DOWNSTREAM = 1'b1;
   localparam logic ROLE_UPSTREAM = 1'b0;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SENDER_RESPONSE_US = 27;
   localparam int SENDER_RESPONSE_CYCLES = SENDER_RESPONSE_US * 1000 / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;

   // ***********************************************
   // states
   // ***********************************************
   typedef enum logic [3:0] {
      SOURCE_READY_STATE = 4'h0,
      SINK_READY_STATE = 4'h1,
      EVALUATE_REQUEST_STATE = 4'h2,
      ACCEPT_REQUEST_STATE = 4'h3,
      REJECT_REQUEST_STATE = 4'h4,
      CHANGE_TO_UPSTREAM_STATE = 4'h5,
      SEND_REQUEST_STATE = 4'h6,
      SOURCE_HARD_RESET_STATE = 4'h7,
      SINK_HARD_RESET_STATE = 4'h8,
      ERROR_RECOVERY_STATE = 4'h9
   } swap_state_t;

   typedef enum logic [2:0] {
      MSG_NONE = 3'h0,
      MSG_ACCEPT = 3'h1,
      MSG_REJECT = 3'h2,
      MSG_WAIT = 3'h3,
      MSG_DR_SWAP = 3'h4
   } msg_kind_t;

   // received-message, send-status and error strobes from the protocol layer
   typedef struct packed {
      logic dr_swap;
      logic accept;
      logic reject;
      logic wait_msg;
      logic sent;
      logic send_failed;
      logic proto_error;
   } proto_rx_t;

endpackage : drs_pkg
